// ===== logic/tsic_pkg.sv
package tsic_pkg;
    // ****************************************
    // Register map and field positions
    // ****************************************
    localparam logic [7:0] INTERRUPT_CONTROL_ADDR      = 8'h0B;
    localparam int         BIT_MASTER_EN  = 0;
    localparam int         BIT_EXT_EN     = 1;
    localparam int         BIT_TMR_EN     = 2;
    localparam int         BIT_EXT_FLAG   = 4;
    localparam int         BIT_TMR_FLAG   = 5;
    localparam logic [7:0] INTERRUPT_CONTROL_RW_MASK   = 8'h37;
    localparam logic [7:0] INTERRUPT_CONTROL_RESET     = 8'h00;

    // ****************************************
    // Vectors and stack
    // ****************************************
    localparam logic [11:0] VEC_EXT       = 12'h004;
    localparam logic [11:0] VEC_TMR       = 12'h008;
    localparam int          STACK_LEVELS  = 6;
    localparam logic [2:0]  STACK_RESET   = 3'h0;

    // ****************************************
    // Machine cycle phases
    // ****************************************
    localparam int          PHASES        = 4;
    localparam logic [1:0]  SAMPLE_PHASE  = 2'h1;

    typedef enum logic [2:0] {
        TSIC_IDLE   = 3'b001,
        TSIC_PUSH   = 3'b010,
        TSIC_BRANCH = 3'b100
    } tsic_state_t;
endpackage

// ===== logic/tsic_edge_detect.sv
`timescale 1ns/10ps
`default_nettype none
module tsic_edge_detect (
    input  wire logic core_clk,
    input  wire logic arst_n,
    input  wire logic pin_async,
    input  wire logic rise_sel,
    output logic      edge_pulse
);
    logic sync1_q;
    logic sync2_q;
    logic prev_q;
    logic rise;
    logic fall;

    // ****************************************
    // Synchroniser and edge choice
    // ****************************************
    // Two stages before anything looks at the pin
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q  <= 1'b0;
        end else begin
            sync1_q <= pin_async;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // Edge sense follows the select level
    always_comb begin
        rise       = sync2_q & ~prev_q;
        fall       = ~sync2_q & prev_q;
        edge_pulse = rise_sel ? rise : fall;
    end
endmodule
`default_nettype wire

// ===== logic/tsic_stack.sv
`timescale 1ns/10ps
`default_nettype none
module tsic_stack #(
    parameter int LEVELS = tsic_pkg::STACK_LEVELS,
    parameter int AW     = 12
) (
    input  wire logic          core_clk,
    input  wire logic          arst_n,
    input  wire logic          push,
    input  wire logic          pop,
    input  wire logic [AW-1:0] push_addr,
    output logic      [AW-1:0] top_addr,
    output logic               full,
    output logic [2:0]         depth
);
    logic [AW-1:0] mem_q [LEVELS];
    logic [AW-1:0] mem_d [LEVELS];
    logic [2:0]    idx_q;
    logic [2:0]    idx_d;

    // ****************************************
    // Return address storage
    // ****************************************
    // Push ignored when full, pop ignored when empty
    always_comb begin
        mem_d = mem_q;
        idx_d = idx_q;
        if (push && !full) begin
            mem_d[idx_q] = push_addr;
            idx_d        = idx_q + 3'h1;
        end else if (pop && idx_q != 3'h0) begin
            idx_d = idx_q - 3'h1;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            idx_q <= tsic_pkg::STACK_RESET;
            for (int i = 0; i < LEVELS; i++) begin
                mem_q[i] <= '0;
            end
        end else begin
            idx_q <= idx_d;
            mem_q <= mem_d;
        end
    end

    // Six levels, full when all hold addresses
    always_comb begin
        full     = (idx_q == 3'(LEVELS));
        depth    = idx_q;
        top_addr = (idx_q == 3'h0) ? '0 : mem_q[idx_q - 3'h1];
    end
endmodule
`default_nettype wire

// ===== logic/tsic_top.sv
`timescale 1ns/10ps
`default_nettype none
module tsic_top (
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    input  wire logic        ext_irq_pin,
    input  wire logic        edge_select_output,
    input  wire logic        timer_overflow,
    input  wire logic        call_req,
    input  wire logic        plain_return,
    input  wire logic        return_with_irq_enable,
    input  wire logic [11:0] pc_now,
    input  wire logic        halted,
    output logic      [11:0] pc_load_addr,
    output logic             pc_load,
    output logic             irq_ack,
    output logic             wake,
    output logic             stack_full,
    output logic             sampling_phase
);
    // ****************************************
    // Declarations
    // ****************************************
    logic [7:0]          interrupt_control_q;
    logic [7:0]          interrupt_control_d;
    logic [1:0]          phase_q;
    logic [1:0]          phase_d;
    logic                sample_pulse;
    logic                ext_edge;
    logic                ext_pend;
    logic                tmr_pend;
    logic                ext_go;
    logic                tmr_go;
    logic                take;
    tsic_pkg::tsic_state_t st_q;
    tsic_pkg::tsic_state_t st_d;
    logic [11:0]         vec_q;
    logic [11:0]         vec_d;
    logic                push;
    logic                pop;
    logic [11:0]         top_addr;
    logic                full;
    logic [11:0]         load_addr_d;
    logic [11:0]         load_addr_q;
    logic                load_d;
    logic                load_q;
    logic                ack_d;
    logic                ack_q;
    logic                wake_q;
    logic                full_q;
    logic                phase_out_q;
    logic [7:0]          rdata_q;
    logic [7:0]          rdata_d;

    // ****************************************
    // Sub-blocks
    // ****************************************
    tsic_edge_detect u_edge (
        .core_clk   (core_clk),
        .arst_n     (arst_n),
        .pin_async  (ext_irq_pin),
        .rise_sel   (edge_select_output),
        .edge_pulse (ext_edge)
    );

    tsic_stack #(
        .LEVELS (tsic_pkg::STACK_LEVELS),
        .AW     (12)
    ) u_stack (
        .core_clk  (core_clk),
        .arst_n    (arst_n),
        .push      (push),
        .pop       (pop),
        .push_addr (pc_now),
        .top_addr  (top_addr),
        .full      (full),
        .depth     ()
    );

    // ****************************************
    // Machine cycle phase counter
    // ****************************************
    // One sample enable per four clocks
    always_comb begin
        phase_d      = phase_q + 2'h1;
        sample_pulse = (phase_q == tsic_pkg::SAMPLE_PHASE);
    end

    // ****************************************
    // Acknowledge decision
    // ****************************************
    // Master gates both sources
    always_comb begin
        ext_pend = interrupt_control_q[tsic_pkg::BIT_EXT_FLAG]
                 & interrupt_control_q[tsic_pkg::BIT_EXT_EN];
        tmr_pend = interrupt_control_q[tsic_pkg::BIT_TMR_FLAG]
                 & interrupt_control_q[tsic_pkg::BIT_TMR_EN];
        take     = sample_pulse & interrupt_control_q[tsic_pkg::BIT_MASTER_EN]
                 & ~full
                 & (st_q == tsic_pkg::TSIC_IDLE) & ~call_req
                 & ~plain_return & ~return_with_irq_enable;
        ext_go   = take & ext_pend;
        tmr_go   = take & tmr_pend & ~ext_pend;
    end

    // ****************************************
    // Service sequencer
    // ****************************************
    // Push then branch; a call or return in the sample cycle holds the request off
    always_comb begin
        st_d        = st_q;
        vec_d       = vec_q;
        push        = 1'b0;
        pop         = plain_return | return_with_irq_enable;
        load_d      = 1'b0;
        ack_d       = 1'b0;
        load_addr_d = load_addr_q;
        unique case (st_q)
            tsic_pkg::TSIC_IDLE: begin
                if (ext_go || tmr_go) begin
                    vec_d = ext_go ? tsic_pkg::VEC_EXT : tsic_pkg::VEC_TMR;
                    st_d  = tsic_pkg::TSIC_PUSH;
                    ack_d = 1'b1;
                end else if (call_req) begin
                    push = 1'b1;
                end else if (pop) begin
                    load_d      = 1'b1;
                    load_addr_d = top_addr;
                end
            end
            tsic_pkg::TSIC_PUSH: begin
                push  = 1'b1;
                pop   = 1'b0;
                st_d  = tsic_pkg::TSIC_BRANCH;
            end
            tsic_pkg::TSIC_BRANCH: begin
                load_d      = 1'b1;
                load_addr_d = vec_q;
                pop         = 1'b0;
                st_d        = tsic_pkg::TSIC_IDLE;
            end
            default: st_d = tsic_pkg::TSIC_IDLE;
        endcase
    end

    // ****************************************
    // Interrupt control register
    // ****************************************
    // Hardware sets beat software clears in the same cycle
    always_comb begin
        interrupt_control_d = interrupt_control_q;
        if (reg_wr && reg_addr == tsic_pkg::INTERRUPT_CONTROL_ADDR) begin
            interrupt_control_d = reg_wdata & tsic_pkg::INTERRUPT_CONTROL_RW_MASK;
        end
        if (return_with_irq_enable && st_q == tsic_pkg::TSIC_IDLE) begin
            interrupt_control_d[tsic_pkg::BIT_MASTER_EN] = 1'b1;
        end
        if (ext_go) begin
            interrupt_control_d[tsic_pkg::BIT_EXT_FLAG]  = 1'b0;
            interrupt_control_d[tsic_pkg::BIT_MASTER_EN] = 1'b0;
        end
        if (tmr_go) begin
            interrupt_control_d[tsic_pkg::BIT_TMR_FLAG]  = 1'b0;
            interrupt_control_d[tsic_pkg::BIT_MASTER_EN] = 1'b0;
        end
        if (ext_edge) begin
            interrupt_control_d[tsic_pkg::BIT_EXT_FLAG] = 1'b1;
        end
        if (timer_overflow) begin
            interrupt_control_d[tsic_pkg::BIT_TMR_FLAG] = 1'b1;
        end
    end

    // Read data, spare bits always zero
    always_comb begin
        rdata_d = 8'h00;
        if (reg_rd && reg_addr == tsic_pkg::INTERRUPT_CONTROL_ADDR) begin
            rdata_d = interrupt_control_q & tsic_pkg::INTERRUPT_CONTROL_RW_MASK;
        end
    end

    // ****************************************
    // State registers
    // ****************************************
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            interrupt_control_q      <= tsic_pkg::INTERRUPT_CONTROL_RESET;
            phase_q     <= 2'h0;
            st_q        <= tsic_pkg::TSIC_IDLE;
            vec_q       <= 12'h000;
            load_addr_q <= 12'h000;
            load_q      <= 1'b0;
            ack_q       <= 1'b0;
            wake_q      <= 1'b0;
            full_q      <= 1'b0;
            phase_out_q <= 1'b0;
            rdata_q     <= 8'h00;
        end else begin
            interrupt_control_q      <= interrupt_control_d;
            phase_q     <= phase_d;
            st_q        <= st_d;
            vec_q       <= vec_d;
            load_addr_q <= load_addr_d;
            load_q      <= load_d;
            ack_q       <= ack_d;
            // Wake on any raised flag, enabled or not
            wake_q      <= halted & (interrupt_control_q[tsic_pkg::BIT_EXT_FLAG]
                          | interrupt_control_q[tsic_pkg::BIT_TMR_FLAG]);
            full_q      <= full;
            phase_out_q <= sample_pulse;
            rdata_q     <= rdata_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    always_comb begin
        pc_load_addr   = load_addr_q;
        pc_load        = load_q;
        irq_ack        = ack_q;
        wake           = wake_q;
        stack_full     = full_q;
        sampling_phase = phase_out_q;
        reg_rdata      = rdata_q;
    end
endmodule
`default_nettype wire

// ===== verif/tsic_chk_sva.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Port checker for the interrupt control
// ****************************************
module tsic_chk (
    input wire logic        core_clk,
    input wire logic        arst_n,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_rdata,
    input wire logic        plain_return,
    input wire logic        return_with_irq_enable,
    input wire logic        halted,
    input wire logic [11:0] pc_load_addr,
    input wire logic        pc_load,
    input wire logic        irq_ack,
    input wire logic        wake,
    input wire logic        stack_full,
    input wire logic        sampling_phase
);
    logic rd_hit;
    // Read of the control address only
    assign rd_hit = reg_rd && (reg_addr == 8'h0B);

    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    sequence s_ack;
        irq_ack;
    endsequence
    sequence s_branch;
        ##2 pc_load && (pc_load_addr == 12'h004 || pc_load_addr == 12'h008);
    endsequence
    property p_service;
        s_ack |-> s_branch;
    endproperty

    chk_service_branch: assert property (p_service)
        else $error("service without vector load");
    // Phase output and acknowledge share one register stage
    chk_ack_on_phase: assert property (irq_ack |->
        sampling_phase)
        else $error("acknowledge off sampling phase");
    chk_phase_period: assert property (sampling_phase |=>
        !sampling_phase [*3] ##1 sampling_phase)
        else $error("sampling phase not every four clocks");
    chk_ack_spacing: assert property (irq_ack |=> !irq_ack [*3])
        else $error("acknowledges too close");
    // Full flag lags the stack by one stage, so it shows the decision cycle
    chk_full_holds: assert property (irq_ack |-> !stack_full)
        else $error("acknowledge while stack full");
    chk_rdata_idle: assert property (!$past(rd_hit) |-> reg_rdata == 8'h00)
        else $error("read data without read");
    chk_spare_zero: assert property (reg_rdata[7:6] == 2'h0 && !reg_rdata[3])
        else $error("spare control bits set");
    chk_wake_cause: assert property (wake |-> $past(halted))
        else $error("wake while running");
    chk_load_cause: assert property (pc_load |-> $past(irq_ack, 2)
        || $past(plain_return) || $past(return_with_irq_enable))
        else $error("program counter load without cause");
endmodule
bind tsic_top tsic_chk u_chk (
    .core_clk, .arst_n, .reg_rd, .reg_addr, .reg_rdata, .plain_return,
    .return_with_irq_enable, .halted, .pc_load_addr, .pc_load, .irq_ack,
    .wake, .stack_full, .sampling_phase
);
`default_nettype wire

// ===== verif/tsic_core_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Core sequencer stand-in
// ****************************************
module tsic_core_model (
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic        pc_load,
    input  wire logic [11:0] pc_load_addr,
    output logic      [11:0] pc_now
);
    logic [11:0] pc_d;
    logic [11:0] pc_q;
    // Holds still so pushed addresses are predictable
    always_comb begin
        pc_d = pc_load ? pc_load_addr : pc_q;
    end
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pc_q <= 12'h000;
        end else begin
            pc_q <= pc_d;
        end
    end
    assign pc_now = pc_q;
endmodule
`default_nettype wire

// ===== verif/testbench.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Self-checking bench
// ****************************************
module testbench;
    logic        core_clk, arst_n, reg_wr, reg_rd, ext_irq_pin, halted;
    logic        edge_select_output, timer_overflow, call_req;
    logic        plain_return, return_with_irq_enable;
    logic        pc_load, irq_ack, wake, stack_full, sampling_phase;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic [11:0] pc_now, pc_load_addr, exp_pc;
    logic [31:0] seed;
    logic [11:0] stk[$];
    int          n_errors = 0;
    int          checked = 0;

    tsic_top DUT (.core_clk, .arst_n, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata, .ext_irq_pin, .edge_select_output,
        .timer_overflow, .call_req, .plain_return, .return_with_irq_enable,
        .pc_now, .halted, .pc_load_addr, .pc_load, .irq_ack, .wake,
        .stack_full, .sampling_phase);
    tsic_core_model u_core (.core_clk, .arst_n, .pc_load, .pc_load_addr,
        .pc_now);

    // Free running clock, 25 ns
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    // Readback keeps only the implemented bits
    function automatic logic [7:0] ctrl_view(input logic [7:0] w);
        return w & 8'h37;
    endfunction

    task automatic close_out;
        if (n_errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [11:0] e,
                       input logic [11:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick(1);
        reg_wr = 1'b0;
        tick(1);
    endtask
    // Read data stands for one cycle only
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr = a;
        reg_rd = 1'b1;
        tick(1);
        reg_rd = 1'b0;
        cmp("control", e, reg_rdata);
        tick(1);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask
    task automatic wait_load(input logic [11:0] e);
        int i;
        for (i = 0; i < 30 && pc_load !== 1'b1; i++) tick(1);
        if (i == 30) begin
            n_errors++;
            close_out;
        end
        cmp("target", e, pc_load_addr);
        tick(1);
    endtask
    task automatic svc(input logic [11:0] v);
        wait_load(v);
        stk.push_back(exp_pc);
        exp_pc = v;
    endtask
    task automatic do_return(ref logic s);
        pulse(s);
        exp_pc = stk.pop_back();
        wait_load(exp_pc);
    endtask
    task automatic none(input int n);
        repeat (n) begin
            tick(1);
            cmp("ack", 12'h000, irq_ack);
        end
    endtask
    task automatic pin(input logic v);
        ext_irq_pin = v;
        tick(6);
    endtask

    // Main sequence
    initial begin
        {reg_wr, reg_rd, ext_irq_pin, edge_select_output, halted} = 5'h00;
        {timer_overflow, call_req, plain_return} = 3'h0;
        return_with_irq_enable = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        arst_n = 1'b0;
        exp_pc = 12'h000;
        seed = 32'h2AEF8924;
        tick(6);
        arst_n = 1'b1;
        tick(2);
        rd(8'h0B, 8'h00);
        wr(8'h0B, 8'hFE);
        rd(8'h0B, 8'h36);
        wr(8'h0A, 8'h00);
        rd(8'h0B, 8'h36);
        rd(8'h0A, 8'h00);
        // Master bit kept off so random data never starts a service
        repeat (8) begin
            seed = xs(seed);
            wr(8'h0B, seed[7:0] & 8'hFE);
            rd(8'h0B, ctrl_view(seed[7:0] & 8'hFE));
        end
        wr(8'h0B, 8'h05);
        pulse(timer_overflow);
        svc(12'h008);
        rd(8'h0B, 8'h04);
        pulse(timer_overflow);
        none(12);
        rd(8'h0B, 8'h24);
        halted = 1'b1;
        tick(3);
        cmp("wake", 12'h001, wake);
        halted = 1'b0;
        wr(8'h0B, 8'h25);
        svc(12'h008);
        do_return(return_with_irq_enable);
        rd(8'h0B, 8'h05);
        wr(8'h0B, 8'h00);
        pulse(timer_overflow);
        edge_select_output = 1'b1;
        pin(1'b1);
        rd(8'h0B, 8'h30);
        wr(8'h0B, 8'h37);
        svc(12'h004);
        rd(8'h0B, 8'h26);
        do_return(plain_return);
        rd(8'h0B, 8'h26);
        wr(8'h0B, 8'h27);
        svc(12'h008);
        pin(1'b0);
        rd(8'h0B, 8'h06);
        edge_select_output = 1'b0;
        pin(1'b1);
        pin(1'b0);
        rd(8'h0B, 8'h16);
        repeat (4) begin
            pulse(call_req);
            stk.push_back(exp_pc);
            tick(1);
            cmp("full", 12'(stk.size() == 6), stack_full);
        end
        wr(8'h0B, 8'h17);
        none(12);
        do_return(plain_return);
        svc(12'h004);
        close_out;
    end
endmodule
`default_nettype wire
